// [core/odcr_regs.sv]
// Output divider configuration bank with output channel six clock path.
// Assumes a byte-wide config port from the serial front end, same clock.
module odcr_regs
	import odcr_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        sys_rst,
	input  wire logic        clk_en,
	input  wire logic [7:0]  cfg_addr,
	input  wire logic [7:0]  cfg_wdata,
	input  wire logic        cfg_wr_en,
	input  wire logic        cfg_rd_en,
	output logic [7:0]       cfg_rdata,
	output logic             cfg_rd_valid,
	output logic [5:0]       out5_output_delay_coarse,
	output logic [1:0]       out5_output_delay_fine,
	output logic [1:0]       out5_supply_level_select,
	output logic [2:0]       out5_driver_standard_select,
	output logic [19:0]      out6_output_divider_value,
	output logic [5:0]       out6_output_delay_coarse,
	output logic [1:0]       out6_output_delay_fine,
	output logic [7:0]       out6_fine_delay_ps,
	output logic [1:0]       out6_supply_level_select,
	output logic [2:0]       out6_se_drive_strength,
	output logic             out6_true_clock,
	output logic             out6_complement_clock,
	output logic             out6_pos_leg_source,
	output logic             out6_neg_leg_source
);

	logic [7:0] regs_r   [ODCR_NUM_REGS];  // Register bank
	logic [7:0] regs_nxt [ODCR_NUM_REGS];
	logic [7:0] rdata_r;                   // Read data holding register
	logic [7:0] rdata_nxt;
	logic       rvalid_r;                  // Read answer strobe
	logic       rvalid_nxt;
	logic [1:0] pos_sel_r;                 // Leg routing, registered
	logic [1:0] pos_sel_nxt;
	logic       pos_r;
	logic       pos_nxt;
	logic       neg_r;
	logic       neg_nxt;
	logic       true_r;
	logic       true_nxt;
	logic       hit;                       // Address maps to bank
	logic [2:0] idx;                       // Decoded bank index
	logic [19:0] div_value;                // Assembled divider
	logic       div_clk;                   // Divided, delayed clock

	// Address decode of the eight mapped offsets
	always_comb
	begin
		hit = 1'b1;
		idx = ODCR_IDX_OUT5_DLY;
		case (cfg_addr)
			ODCR_OUT5_DELAY_CTRL_OFS: idx = ODCR_IDX_OUT5_DLY;
			ODCR_OUT5_DRIVER_CFG_OFS: idx = ODCR_IDX_OUT5_DRV;
			ODCR_OUT6_DIV_UPPER_OFS:  idx = ODCR_IDX_DIV_UP;
			ODCR_OUT6_DIV_MIDDLE_OFS: idx = ODCR_IDX_DIV_MID;
			ODCR_OUT6_DIV_LOWER_OFS:  idx = ODCR_IDX_DIV_LOW;
			ODCR_OUT6_SE_CFG_OFS:     idx = ODCR_IDX_SE_CFG;
			ODCR_OUT6_DELAY_CTRL_OFS: idx = ODCR_IDX_OUT6_DLY;
			ODCR_OUT6_SUPPLY_CFG_OFS: idx = ODCR_IDX_OUT6_SUP;
			default:                  hit = 1'b0;
		endcase
	end

	// Next values of each register: write replaces all eight bits
	genvar gi;
	generate
		for (gi = 0; gi < ODCR_NUM_REGS; gi++)
		begin : g_reg
			always_comb
			begin
				regs_nxt[gi] = regs_r[gi];
				if (cfg_wr_en && hit && (idx == 3'(gi)))
					regs_nxt[gi] = cfg_wdata;
			end

			always_ff @(posedge clock or posedge sys_rst)
			begin
				if (sys_rst)
					regs_r[gi] <= ODCR_REG_RST;
				else if (clk_en)
					regs_r[gi] <= regs_nxt[gi];
			end
		end
	endgenerate

	// Read path: one cycle latency, unmapped reads return zero
	always_comb
	begin
		rvalid_nxt = cfg_rd_en;
		rdata_nxt  = rdata_r;
		if (cfg_rd_en)
		begin
			if (hit)
				rdata_nxt = regs_r[idx];
			else
				rdata_nxt = ODCR_UNMAPPED;
		end
	end

	// Read registers
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			rdata_r  <= ODCR_REG_RST;
			rvalid_r <= 1'b0;
		end
		else if (clk_en)
		begin
			rdata_r  <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
		end
	end

	assign cfg_rdata    = rdata_r;
	assign cfg_rd_valid = rvalid_r;

	// Divider assembled from three bytes
	assign div_value = {regs_r[ODCR_IDX_DIV_UP][ODCR_DIVUP_MSB:0],
		regs_r[ODCR_IDX_DIV_MID],
		regs_r[ODCR_IDX_DIV_LOW]};

	// Channel six clock generation
	odcr_divider #(
		.DIV_W (ODCR_DIV_W),
		.DLY_W (ODCR_COARSE_W)
	) u_div6 (
		.clock         (clock),
		.sys_rst       (sys_rst),
		.clk_en        (clk_en),
		.divider_value (div_value),
		.coarse_delay  (regs_r[ODCR_IDX_OUT6_DLY][ODCR_COARSE_MSB:
			ODCR_COARSE_LSB]),
		.clk_out       (div_clk)
	);

	// Single-ended leg routing from the phase field
	always_comb
	begin
		pos_sel_nxt = regs_r[ODCR_IDX_SE_CFG][ODCR_PHASE_MSB:ODCR_PHASE_LSB];
		true_nxt    = div_clk;
		case (odcr_phase_t'(pos_sel_r))
			ODCR_PH_TRUE_COMP:
			begin
				pos_nxt = true_r;
				neg_nxt = ~true_r;
			end
			ODCR_PH_TRUE_TRUE:
			begin
				pos_nxt = true_r;
				neg_nxt = true_r;
			end
			ODCR_PH_COMP_COMP:
			begin
				pos_nxt = ~true_r;
				neg_nxt = ~true_r;
			end
			ODCR_PH_COMP_TRUE:
			begin
				pos_nxt = ~true_r;
				neg_nxt = true_r;
			end
			default:
			begin
				pos_nxt = true_r;
				neg_nxt = ~true_r;
			end
		endcase
	end

	// Leg and clock registers
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pos_sel_r <= 2'h0;
			true_r    <= 1'b0;
			pos_r     <= 1'b0;
			neg_r     <= 1'b1;
		end
		else if (clk_en)
		begin
			pos_sel_r <= pos_sel_nxt;
			true_r    <= true_nxt;
			pos_r     <= pos_nxt;
			neg_r     <= neg_nxt;
		end
	end

	assign out6_true_clock       = true_r;
	assign out6_complement_clock = ~true_r;
	assign out6_pos_leg_source   = pos_r;
	assign out6_neg_leg_source   = neg_r;

	// Configuration fields straight from the bank
	assign out5_output_delay_coarse =
		regs_r[ODCR_IDX_OUT5_DLY][ODCR_COARSE_MSB:ODCR_COARSE_LSB];
	assign out5_output_delay_fine =
		regs_r[ODCR_IDX_OUT5_DLY][ODCR_FINE_MSB:ODCR_FINE_LSB];
	assign out5_supply_level_select =
		regs_r[ODCR_IDX_OUT5_DRV][ODCR_SUPPLY_MSB:ODCR_SUPPLY_LSB];
	assign out5_driver_standard_select =
		regs_r[ODCR_IDX_OUT5_DRV][ODCR_DRV_MSB:ODCR_DRV_LSB];
	assign out6_output_divider_value = div_value;
	assign out6_output_delay_coarse =
		regs_r[ODCR_IDX_OUT6_DLY][ODCR_COARSE_MSB:ODCR_COARSE_LSB];
	assign out6_output_delay_fine =
		regs_r[ODCR_IDX_OUT6_DLY][ODCR_FINE_MSB:ODCR_FINE_LSB];
	// Fine delay in picoseconds for the analog trim
	assign out6_fine_delay_ps = 8'(out6_output_delay_fine
		* ODCR_FINE_STEP_PS);
	assign out6_supply_level_select =
		regs_r[ODCR_IDX_OUT6_SUP][ODCR_SUPPLY_MSB:ODCR_SUPPLY_LSB];
	// Strength is taken as written; software should write seven
	assign out6_se_drive_strength =
		regs_r[ODCR_IDX_SE_CFG][ODCR_STR_MSB:ODCR_STR_LSB];

endmodule : odcr_regs

// [core/odcr_pkg.sv]
// Constants, field layouts and encodings for the output divider config bank.
// Assumes a byte-wide configuration port in the same clock domain.
package odcr_pkg;

	// Register offsets on the configuration port
	localparam logic [7:0] ODCR_OUT5_DELAY_CTRL_OFS  = 8'h3C;
	localparam logic [7:0] ODCR_OUT5_DRIVER_CFG_OFS  = 8'h3D;
	localparam logic [7:0] ODCR_OUT6_DIV_UPPER_OFS   = 8'h40;
	localparam logic [7:0] ODCR_OUT6_DIV_MIDDLE_OFS  = 8'h41;
	localparam logic [7:0] ODCR_OUT6_DIV_LOWER_OFS   = 8'h42;
	localparam logic [7:0] ODCR_OUT6_SE_CFG_OFS      = 8'h43;
	localparam logic [7:0] ODCR_OUT6_DELAY_CTRL_OFS  = 8'h44;
	localparam logic [7:0] ODCR_OUT6_SUPPLY_CFG_OFS  = 8'h45;

	// Number of registers and their common reset value
	localparam int         ODCR_NUM_REGS = 8;
	localparam logic [7:0] ODCR_REG_RST  = 8'h00;
	localparam logic [7:0] ODCR_UNMAPPED = 8'h00;

	// Register indices inside the bank
	localparam logic [2:0] ODCR_IDX_OUT5_DLY = 3'h0;
	localparam logic [2:0] ODCR_IDX_OUT5_DRV = 3'h1;
	localparam logic [2:0] ODCR_IDX_DIV_UP   = 3'h2;
	localparam logic [2:0] ODCR_IDX_DIV_MID  = 3'h3;
	localparam logic [2:0] ODCR_IDX_DIV_LOW  = 3'h4;
	localparam logic [2:0] ODCR_IDX_SE_CFG   = 3'h5;
	localparam logic [2:0] ODCR_IDX_OUT6_DLY = 3'h6;
	localparam logic [2:0] ODCR_IDX_OUT6_SUP = 3'h7;

	// Field positions
	localparam int ODCR_COARSE_LSB = 0;
	localparam int ODCR_COARSE_MSB = 5;
	localparam int ODCR_FINE_LSB   = 6;
	localparam int ODCR_FINE_MSB   = 7;
	localparam int ODCR_SUPPLY_LSB = 3;
	localparam int ODCR_SUPPLY_MSB = 4;
	localparam int ODCR_DRV_LSB    = 0;
	localparam int ODCR_DRV_MSB    = 2;
	localparam int ODCR_PHASE_LSB  = 6;
	localparam int ODCR_PHASE_MSB  = 7;
	localparam int ODCR_STR_LSB    = 0;
	localparam int ODCR_STR_MSB    = 2;
	localparam int ODCR_DIVUP_MSB  = 3;

	// Widths and counts
	localparam int ODCR_DIV_W       = 20;
	localparam int ODCR_COARSE_W    = 6;
	localparam int ODCR_FINE_STEP_PS = 30;
	localparam logic [2:0] ODCR_SE_STRENGTH_REC = 3'h7;

	// Supply level codes
	typedef enum logic [1:0] {
		ODCR_VDD_1V8 = 2'h0,
		ODCR_VDD_2V5 = 2'h1,
		ODCR_VDD_3V3 = 2'h2
	} odcr_supply_t;

	// Driver standard codes
	typedef enum logic [2:0] {
		ODCR_DRV_LVDS       = 3'h0,
		ODCR_DRV_LVPECL_CM  = 3'h1,
		ODCR_DRV_CML        = 3'h2,
		ODCR_DRV_HCSL       = 3'h3,
		ODCR_DRV_LVDS_BOOST = 3'h4,
		ODCR_DRV_LVPECL_NCM = 3'h5
	} odcr_driver_t;

	// Single-ended phase routing codes
	typedef enum logic [1:0] {
		ODCR_PH_TRUE_COMP = 2'h0,
		ODCR_PH_TRUE_TRUE = 2'h1,
		ODCR_PH_COMP_COMP = 2'h2,
		ODCR_PH_COMP_TRUE = 2'h3
	} odcr_phase_t;

endpackage : odcr_pkg

// [core/odcr_divider.sv]
// Output channel divider with coarse delay line.
// Assumes the source clock is the module clock, gated by clk_en.
module odcr_divider
	import odcr_pkg::*;
#(
	parameter int DIV_W = ODCR_DIV_W,
	parameter int DLY_W = ODCR_COARSE_W
)
(
	input  wire logic             clock,
	input  wire logic             sys_rst,
	input  wire logic             clk_en,
	input  wire logic [DIV_W-1:0] divider_value,
	input  wire logic [DLY_W-1:0] coarse_delay,
	output logic                  clk_out
);

	localparam int LINE_LEN = (1 << DLY_W) - 1;

	logic [DIV_W-1:0]    count_r;     // Position within one output period
	logic [DIV_W-1:0]    count_nxt;
	logic                raw_r;       // Undelayed divided clock
	logic                raw_nxt;
	logic [LINE_LEN-1:0] line_r;      // One tap per source period
	logic [LINE_LEN-1:0] line_nxt;
	logic                out_r;       // Delayed, registered output
	logic                out_nxt;
	logic [DIV_W-1:0]    half;

	assign half = divider_value >> 1;

	// Divide, delay and select tap
	always_comb
	begin
		count_nxt = count_r;
		raw_nxt   = raw_r;
		line_nxt  = {line_r[LINE_LEN-2:0], raw_r};
		if (divider_value < DIV_W'(2))
		begin
			// Zero and one cannot divide: hold low
			count_nxt = '0;
			raw_nxt   = 1'b0;
		end
		else
		begin
			// Wrap at value minus one, even if the value shrank
			if (count_r >= divider_value - DIV_W'(1))
				count_nxt = '0;
			else
				count_nxt = count_r + DIV_W'(1);
			raw_nxt = (count_nxt < (divider_value - half));
		end
		// Tap zero is the undelayed clock
		if (coarse_delay == '0)
			out_nxt = raw_r;
		else
			out_nxt = line_r[coarse_delay - DLY_W'(1)];
	end

	// State registers, frozen by clock enable
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			count_r <= '0;
			raw_r   <= 1'b0;
			line_r  <= '0;
			out_r   <= 1'b0;
		end
		else if (clk_en)
		begin
			count_r <= count_nxt;
			raw_r   <= raw_nxt;
			line_r  <= line_nxt;
			out_r   <= out_nxt;
		end
	end

	assign clk_out = out_r;

endmodule : odcr_divider

// [tb/odcr_chk.sv]
// Port-level assertions for the output divider config bank.
// Assumes it is bound onto odcr_regs and sees only that module's ports.
module odcr_chk
	import odcr_pkg::*;
(
	input wire logic        clock,
	input wire logic        sys_rst,
	input wire logic        clk_en,
	input wire logic [7:0]  cfg_addr,
	input wire logic [7:0]  cfg_wdata,
	input wire logic        cfg_wr_en,
	input wire logic        cfg_rd_en,
	input wire logic [7:0]  cfg_rdata,
	input wire logic        cfg_rd_valid,
	input wire logic [5:0]  out5_output_delay_coarse,
	input wire logic [1:0]  out5_output_delay_fine,
	input wire logic [1:0]  out5_supply_level_select,
	input wire logic [2:0]  out5_driver_standard_select,
	input wire logic [19:0] out6_output_divider_value,
	input wire logic [5:0]  out6_output_delay_coarse,
	input wire logic [1:0]  out6_output_delay_fine,
	input wire logic [7:0]  out6_fine_delay_ps,
	input wire logic [1:0]  out6_supply_level_select,
	input wire logic [2:0]  out6_se_drive_strength,
	input wire logic        out6_true_clock,
	input wire logic        out6_complement_clock,
	input wire logic        out6_pos_leg_source,
	input wire logic        out6_neg_leg_source
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	// Write strobe that the bank accepts
	logic wr_ok;
	assign wr_ok = clk_en & cfg_wr_en;
	// Shadow of the phase field, followed through the port writes
	logic [1:0] phase_sh;
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			phase_sh <= 2'h0;
		else if (wr_ok && cfg_addr == 8'h43)
			phase_sh <= cfg_wdata[7:6];
	end
	// Read answer comes one cycle on and lasts one cycle
	a_rd_answer: assert property (clk_en && cfg_rd_en |=> cfg_rd_valid)
		else $error("read valid missing");
	a_rd_single: assert property (clk_en && !cfg_rd_en |=> !cfg_rd_valid)
		else $error("read valid without read");
	// Upper and lower divider bytes land in their own slices
	a_div_upper: assert property (
		wr_ok && cfg_addr == 8'h40 |=>
		out6_output_divider_value[19:16] == $past(cfg_wdata[3:0]))
		else $error("divider upper nibble wrong");
	a_div_lower: assert property (
		wr_ok && cfg_addr == 8'h42 |=>
		out6_output_divider_value[7:0] == $past(cfg_wdata))
		else $error("divider low byte wrong");
	// Delay and supply fields of output six, output five driver fields, complement clock
	a_dly_fields: assert property (
		wr_ok && cfg_addr == 8'h44 |=>
		{out6_output_delay_fine, out6_output_delay_coarse} == $past(cfg_wdata))
		else $error("delay fields wrong");
	a_fine_ps: assert property (
		out6_fine_delay_ps == 8'(out6_output_delay_fine) * 8'h1E)
		else $error("fine delay ps wrong");
	a_supply_six: assert property (
		wr_ok && cfg_addr == 8'h45 |=>
		out6_supply_level_select == $past(cfg_wdata[4:3]))
		else $error("supply field wrong");
	a_drv_five: assert property (
		wr_ok && cfg_addr == 8'h3D |=> {out5_supply_level_select,
		out5_driver_standard_select} == $past(cfg_wdata[4:0]))
		else $error("driver field wrong");
	a_comp_inv: assert property (
		out6_complement_clock != out6_true_clock)
		else $error("complement not inverse");
	// Legs follow the true clock one cycle late, per steady phase code
	a_leg_route: assert property (
		clk_en && $past(clk_en) && phase_sh == $past(phase_sh) |=>
		out6_pos_leg_source ==
		($past(out6_true_clock) ^ $past(phase_sh[1])) &&
		out6_neg_leg_source ==
		($past(out6_true_clock) ^ ~$past(phase_sh[0])))
		else $error("leg routing wrong");
	// Main scenarios reached
	c_read: cover property (clk_en && cfg_rd_en);
	c_rise: cover property ($rose(out6_true_clock));
	c_legs: cover property (out6_pos_leg_source && out6_neg_leg_source);
endmodule : odcr_chk

bind odcr_regs odcr_chk u_chk (
	.clock                       (clock),
	.sys_rst                     (sys_rst),
	.clk_en                      (clk_en),
	.cfg_addr                    (cfg_addr),
	.cfg_wdata                   (cfg_wdata),
	.cfg_wr_en                   (cfg_wr_en),
	.cfg_rd_en                   (cfg_rd_en),
	.cfg_rdata                   (cfg_rdata),
	.cfg_rd_valid                (cfg_rd_valid),
	.out5_output_delay_coarse    (out5_output_delay_coarse),
	.out5_output_delay_fine      (out5_output_delay_fine),
	.out5_supply_level_select    (out5_supply_level_select),
	.out5_driver_standard_select (out5_driver_standard_select),
	.out6_output_divider_value   (out6_output_divider_value),
	.out6_output_delay_coarse    (out6_output_delay_coarse),
	.out6_output_delay_fine      (out6_output_delay_fine),
	.out6_fine_delay_ps          (out6_fine_delay_ps),
	.out6_supply_level_select    (out6_supply_level_select),
	.out6_se_drive_strength      (out6_se_drive_strength),
	.out6_true_clock             (out6_true_clock),
	.out6_complement_clock       (out6_complement_clock),
	.out6_pos_leg_source         (out6_pos_leg_source),
	.out6_neg_leg_source         (out6_neg_leg_source)
);

// [tb/tb_top.sv]
// Self-checking bench for the output divider config bank.
// Assumes odcr_regs on a byte strobe port, one 10 MHz clock.
`define CHK(a, e, m) begin checks++; if ((a) !== (e)) begin n_errors++; \
	$display("MISMATCH t=%0t %s", $time, m); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import odcr_pkg::*;
	logic clock = 0, sys_rst = 1, clk_en = 1, cfg_wr_en = 0, cfg_rd_en = 0;
	logic [7:0] cfg_addr = 8'h00, cfg_wdata = 8'h00, cfg_rdata, v;
	logic [5:0] out5_output_delay_coarse, out6_output_delay_coarse;
	logic [1:0] out5_output_delay_fine, out6_output_delay_fine;
	logic [1:0] out5_supply_level_select, out6_supply_level_select;
	logic [2:0] out5_driver_standard_select, out6_se_drive_strength;
	logic [19:0] out6_output_divider_value;
	logic [7:0] out6_fine_delay_ps;
	logic cfg_rd_valid, out6_true_clock, out6_complement_clock;
	logic out6_pos_leg_source, out6_neg_leg_source;
	int n_errors = 0, checks = 0, cyc = 0, a, b, c, h;
	// Rows: offset, data written, data read back
	logic [23:0] rows [8] = '{24'h3C9A9A, 24'h3D2B2B, 24'h40A5A5,
		24'h413C3C, 24'h428181, 24'h434747, 24'h443F3F, 24'h451717};
	// Expected {pos, neg} legs per phase code, true low
	logic [1:0] legs [4] = '{2'b01, 2'b00, 2'b11, 2'b10};
	odcr_regs DUT (
		.clock                       (clock),
		.sys_rst                     (sys_rst),
		.clk_en                      (clk_en),
		.cfg_addr                    (cfg_addr),
		.cfg_wdata                   (cfg_wdata),
		.cfg_wr_en                   (cfg_wr_en),
		.cfg_rd_en                   (cfg_rd_en),
		.cfg_rdata                   (cfg_rdata),
		.cfg_rd_valid                (cfg_rd_valid),
		.out5_output_delay_coarse    (out5_output_delay_coarse),
		.out5_output_delay_fine      (out5_output_delay_fine),
		.out5_supply_level_select    (out5_supply_level_select),
		.out5_driver_standard_select (out5_driver_standard_select),
		.out6_output_divider_value   (out6_output_divider_value),
		.out6_output_delay_coarse    (out6_output_delay_coarse),
		.out6_output_delay_fine      (out6_output_delay_fine),
		.out6_fine_delay_ps          (out6_fine_delay_ps),
		.out6_supply_level_select    (out6_supply_level_select),
		.out6_se_drive_strength      (out6_se_drive_strength),
		.out6_true_clock             (out6_true_clock),
		.out6_complement_clock       (out6_complement_clock),
		.out6_pos_leg_source         (out6_pos_leg_source),
		.out6_neg_leg_source         (out6_neg_leg_source)
	);
	always #50 clock = ~clock;
	// Cycle count and hang ceiling
	always @(posedge clock)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			n_errors++;
			results();
		end
	end
	// One accepted write
	task wr(input logic [7:0] ad, input logic [7:0] d);
		@(posedge clock);
		cfg_addr <= ad;
		cfg_wdata <= d;
		cfg_wr_en <= 1'b1;
		@(posedge clock);
		cfg_wr_en <= 1'b0;
		#1;
	endtask : wr
	// One read, answer sampled in its valid cycle
	task rd(input logic [7:0] ad, output logic [7:0] d);
		@(posedge clock);
		cfg_addr <= ad;
		cfg_rd_en <= 1'b1;
		@(posedge clock);
		cfg_rd_en <= 1'b0;
		#1;
		`CHK(cfg_rd_valid, 1'b1, "no read valid")
		d = cfg_rdata;
	endtask : rd
	// Cycle number of the next rising edge of the output clock
	task rise(output int r);
		int k;
		k = 0;
		while (out6_true_clock !== 1'b0 && k < 200)
		begin
			@(posedge clock);
			#1;
			k++;
		end
		while (out6_true_clock !== 1'b1 && k < 200)
		begin
			@(posedge clock);
			#1;
			k++;
		end
		r = cyc;
	endtask : rise
	// Verdict and end of run
	task results();
		$display("checks=%0d n_errors=%0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : results
	// Main sequence
	initial
	begin
		repeat (8) @(posedge clock);
		sys_rst <= 1'b0;
		foreach (rows[i])
		begin
			rd(rows[i][23:16], v);
			`CHK(v, 8'h00, "reset value")
		end
		foreach (rows[i]) wr(rows[i][23:16], rows[i][15:8]);
		foreach (rows[i])
		begin
			rd(rows[i][23:16], v);
			`CHK(v, rows[i][7:0], "readback")
		end
		`CHK(out6_output_divider_value, 20'h53C81, "divider")
		`CHK(out5_output_delay_coarse, 6'h1A, "coarse")
		`CHK(out6_output_delay_coarse, 6'h3F, "coarse max")
		`CHK(out5_output_delay_fine, 2'h2, "fine")
		`CHK(out6_supply_level_select, 2'h2, "supply six")
		for (int i = 0; i < 6; i++)
		begin
			wr(8'h3D, 8'(i % 3 * 8 + i));
			`CHK(out5_driver_standard_select, 3'(i), "drv")
			`CHK(out5_supply_level_select, 2'(i % 3), "supply")
		end
		wr(8'h3E, 8'h77);
		rd(8'h3E, v);
		`CHK(v, 8'h00, "unmapped")
		@(posedge clock) clk_en <= 1'b0;
		wr(8'h41, 8'hFF);
		@(posedge clock) clk_en <= 1'b1;
		rd(8'h41, v);
		`CHK(v, 8'h3C, "write while frozen")
		wr(8'h40, 8'h00);
		wr(8'h41, 8'h00);
		wr(8'h42, 8'h10);
		wr(8'h44, 8'h00);
		repeat (40) @(posedge clock);
		rise(a);
		h = 0;
		while (out6_true_clock === 1'b1 && h < 100)
		begin
			@(posedge clock);
			#1;
			h++;
		end
		`CHK(h, 8, "high time")
		rise(b);
		`CHK(b - a, 16, "period")
		for (int i = 0; i < 4; i++)
		begin
			wr(8'h44, 8'(i * 64 + 5));
			`CHK(out6_fine_delay_ps, 8'(i * 30), "ps")
			`CHK(out6_output_delay_fine, 2'(i), "fine six")
		end
		repeat (200) @(posedge clock);
		rise(c);
		`CHK((c - a) % 16, 5, "coarse delay")
		wr(8'h42, 8'h00);
		repeat (100) @(posedge clock);
		#1;
		`CHK({out6_true_clock, out6_complement_clock}, 2'b01, "low")
		for (int i = 0; i < 4; i++)
		begin
			wr(8'h43, 8'(i * 64 + 7));
			repeat (3) @(posedge clock);
			#1;
			`CHK({out6_pos_leg_source, out6_neg_leg_source}, legs[i], "leg")
			`CHK(out6_se_drive_strength, 3'h7, "strength")
		end
		// Mid-run reset puts legs and registers back to idle
		@(posedge clock) sys_rst <= 1'b1;
		#1;
		`CHK({out6_pos_leg_source, out6_neg_leg_source}, 2'b01, "rst legs")
		`CHK(out6_se_drive_strength, 3'h0, "rst strength")
		`CHK(cfg_rd_valid, 1'b0, "rst valid")
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		rd(8'h43, v);
		`CHK(v, 8'h00, "rst readback")
		results();
	end
endmodule : tb_top
